//--- design/ces_defs.svh
// constants for the camera exposure trigger sequencer
// Summary of operation
// - mode field picks six behaviours or off
// - off mode ignores trigger line, free-runs
// - polarity picks line high or low active
// - shutter_timed_single: activation starts shutter-timed exposure, transfer
// - level_gated_single: expose while trigger stays active
// - level_gated_single: inactive trigger ends exposure, then transfer
// - multi_pulse_accumulate: one frame accumulates over N activations, two when N is below 2
// - internal_periodic: internal continuous triggers, shutter-timed frames
// - internal_periodic: period is N fastest frame periods
// - shutter_timed_multi_frame: N shutter-timed frames, then transfer
// - level_gated_multi_frame: N level-gated frames, then transfer
// - software command triggers like hardware line
`ifndef CES_DEFS_SVH
`define CES_DEFS_SVH

// register bus widths
`define CES_ADDR_W          8
`define CES_DATA_W          32

// register byte offsets
`define CES_OFF_CTRL        8'h00
`define CES_OFF_ARG         8'h04
`define CES_OFF_SHUTTER     8'h08
`define CES_OFF_PERIOD      8'h0C
`define CES_OFF_SWTRIG      8'h10
`define CES_OFF_STATUS      8'h14
`define CES_OFF_FRAMES      8'h18

// control register fields
`define CES_CTRL_ACQ_BIT    0
`define CES_CTRL_MODE_LSB   1
`define CES_CTRL_MODE_MSB   3
`define CES_CTRL_POL_BIT    4
`define CES_CTRL_SRC_BIT    5
`define CES_CTRL_W          6

// software trigger register field
`define CES_SWTRIG_BIT      0

// status register fields
`define CES_STAT_STATE_LSB  0
`define CES_STAT_STATE_MSB  4
`define CES_STAT_LINE_BIT   8
`define CES_STAT_LEFT_LSB   16

// reset values
`define CES_CTRL_RST        6'h0C
`define CES_ARG_RST         1
`define CES_CLK_PERIOD_NS   100
`define CES_SHUTTER_RST_NS  10000
`define CES_PERIOD_RST_NS   100000
`define CES_SHUTTER_RST_CYC (`CES_SHUTTER_RST_NS / `CES_CLK_PERIOD_NS)
`define CES_PERIOD_RST_CYC  (`CES_PERIOD_RST_NS / `CES_CLK_PERIOD_NS)

`endif

//--- design/ces_pkg.sv
// types of the camera exposure trigger sequencer
package ces_pkg;

    // trigger behaviour codes held in the control register
    typedef enum logic [2:0] {
        mode_shutter_timed_single      = 3'h0,
        mode_level_gated_single        = 3'h1,
        mode_multi_pulse_accumulate    = 3'h2,
        mode_internal_periodic         = 3'h3,
        mode_shutter_timed_multi_frame = 3'h4,
        mode_level_gated_multi_frame   = 3'h5,
        mode_trig_off                  = 3'h6
    } ces_mode_e;

    // sequencer states, one-hot
    typedef enum logic [4:0] {
        st_idle    = 5'b00001,
        st_arm     = 5'b00010,
        st_expose  = 5'b00100,
        st_between = 5'b01000,
        st_xfer    = 5'b10000
    } ces_state_e;

endpackage : ces_pkg

//--- design/ces_trig_cond.sv
// trigger line polarity conditioner and activation edge finder
`timescale 1ns/1ns
`default_nettype none

module ces_trig_cond (
    input  wire logic clk,         // system clock
    input  wire logic srst,        // synchronous reset
    input  wire logic trig_line,   // raw trigger line
    input  wire logic pol_low,     // 1: active when line low
    output logic      active,      // conditioned active level
    output logic      activate     // one-cycle pulse on becoming active
);

    logic active_ff;   // active level, registered
    logic prev_ff;     // active level one cycle ago
    logic rise_ff;     // registered activation pulse

    // polarity applied, then edge found
    always_ff @(posedge clk) begin
        if (srst) begin
            active_ff <= 1'b0;
            prev_ff   <= 1'b0;
            rise_ff   <= 1'b0;
        end else begin
            active_ff <= trig_line ^ pol_low;
            prev_ff   <= active_ff;
            rise_ff   <= active_ff & ~prev_ff;
        end
    end

    assign active   = active_ff;
    assign activate = rise_ff;

endmodule // ces_trig_cond
`default_nettype wire

//--- design/ces_tick_timer.sv
// loadable down counter giving an expiry pulse
`timescale 1ns/1ns
`default_nettype none

module ces_tick_timer #(
    parameter int W = 24   // counter width
) (
    input  wire logic         clk,       // system clock
    input  wire logic         srst,      // synchronous reset
    input  wire logic         load,      // start a new count
    input  wire logic [W-1:0] load_val,  // cycles until expiry
    input  wire logic         stop,      // abandon the count
    output logic              expire     // high in the last counted cycle
);

    logic [W-1:0] cnt_ff;   // cycles remaining

    generate
        if (W < 2 || W > 32) begin : g_bad_w
            $error("ces_tick_timer width out of range");
        end
    endgenerate

    // load wins over stop and over counting
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_ff <= '0;
        end else if (load) begin
            cnt_ff <= load_val;
        end else if (stop) begin
            cnt_ff <= '0;
        end else if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 1'b1;
        end
    end

    // a value of 1 left means this is the final cycle
    // not gated by load: callers form load from expire, so that would loop
    assign expire = (cnt_ff == {{(W-1){1'b0}}, 1'b1}) & ~stop;

endmodule // ces_tick_timer
`default_nettype wire

//--- design/ces_sequencer.sv
// exposure trigger sequencer top with register port
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "ces_defs.svh"

module ces_sequencer #(
    parameter int ARG_W  = 16,  // width of the count or period argument
    parameter int TIME_W = 24   // width of shutter and period counts
) (
    input  wire logic                   clk,           // 10 MHz system clock
    input  wire logic                   srst,          // synchronous reset
    input  wire logic                   trig_line,     // external trigger line
    input  wire logic [`CES_ADDR_W-1:0] reg_addr,      // register byte address
    input  wire logic [`CES_DATA_W-1:0] reg_wdata,     // register write data
    input  wire logic                   reg_wr,        // write strobe
    input  wire logic                   reg_rd,        // read strobe
    output logic      [`CES_DATA_W-1:0] reg_rdata,     // read data, cycle after strobe
    input  wire logic                   xfer_done,     // image taken by transport
    output logic                        integrating,   // sensor integrating
    output logic                        frame_start,   // pulse at each exposure start
    output logic                        xfer_req       // image ready for transfer
);

    // elaboration checks
    generate
        if (ARG_W < 2 || ARG_W > 32) begin : g_bad_arg
            $error("ces_sequencer ARG_W out of range");
        end
        if (TIME_W < 2 || TIME_W > 32) begin : g_bad_time
            $error("ces_sequencer TIME_W out of range");
        end
    endgenerate

    localparam logic [ARG_W-1:0]  ARG_ONE   = {{(ARG_W-1){1'b0}}, 1'b1};   // argument one
    localparam logic [ARG_W-1:0]  ARG_RST   = ARG_W'(`CES_ARG_RST);        // argument reset
    localparam logic [TIME_W-1:0] SHUT_RST  = TIME_W'(`CES_SHUTTER_RST_CYC); // shutter reset
    localparam logic [TIME_W-1:0] PER_RST   = TIME_W'(`CES_PERIOD_RST_CYC);  // period reset
    localparam logic [TIME_W-1:0] TIME_ONE  = {{(TIME_W-1){1'b0}}, 1'b1};  // one cycle

    // ---------------- registers ----------------
    logic [`CES_CTRL_W-1:0] ctrl_ff;       // control word
    logic [ARG_W-1:0]       arg_ff;        // trigger count or period argument
    logic [TIME_W-1:0]      shutter_ff;    // exposure length in cycles
    logic [TIME_W-1:0]      period_ff;     // fastest frame period in cycles
    logic                   sw_cmd_ff;     // software trigger command pulse
    logic [15:0]            frames_ff;     // completed transfers
    logic [`CES_DATA_W-1:0] rdata_ff;      // read data holder

    // ---------------- sequencer state ----------------
    ces_pkg::ces_state_e    state_ff;      // current state
    ces_pkg::ces_state_e    nxt_state;     // next state
    logic [ARG_W-1:0]       left_ff;       // frames or activations left
    logic [ARG_W-1:0]       nxt_left;      // next frames left
    logic [ARG_W-1:0]       per_cnt_ff;    // fastest periods counted
    logic                   frame_st_ff;   // registered exposure start pulse

    // ---------------- decoded fields ----------------
    ces_pkg::ces_mode_e     mode;          // selected behaviour
    logic                   acq_en;        // acquisition running
    logic                   pol_low;       // line active when low
    logic                   src_sw;        // software command as source
    logic                   line_act;      // conditioned line level
    logic                   line_rise;     // line activation pulse
    logic                   hw_or_sw_rise; // activation from selected source
    logic                   level_now;     // level used by gated modes
    logic                   int_tick;      // internal periodic trigger
    logic                   start_evt;     // event that opens a sequence
    logic                   shut_load;     // start shutter timer
    logic                   shut_exp;      // shutter timer expiry
    logic                   sub_load;      // start one fastest period
    logic                   sub_exp;       // one fastest period elapsed
    logic                   per_run;       // period generator active
    logic                   expo_end;      // current exposure ends
    logic                   seq_last;      // final frame of the sequence
    logic                   wr_ctrl;       // write to control
    logic                   wr_arg;        // write to argument

    // register address match, used by write and read decode
    function automatic logic hit(input logic [`CES_ADDR_W-1:0] a,
                                 input logic [`CES_ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    // modes whose exposure length follows the trigger level
    function automatic logic is_gated(input ces_pkg::ces_mode_e m);
        is_gated = (m == ces_pkg::mode_level_gated_single) ||
                   (m == ces_pkg::mode_level_gated_multi_frame);
    endfunction

    // field extraction
    assign mode    = (ctrl_ff[`CES_CTRL_MODE_MSB:`CES_CTRL_MODE_LSB] > 3'h6) ?
                     ces_pkg::mode_trig_off :
                     ces_pkg::ces_mode_e'(ctrl_ff[`CES_CTRL_MODE_MSB:`CES_CTRL_MODE_LSB]);
    assign acq_en  = ctrl_ff[`CES_CTRL_ACQ_BIT];
    assign pol_low = ctrl_ff[`CES_CTRL_POL_BIT];
    assign src_sw  = ctrl_ff[`CES_CTRL_SRC_BIT];
    assign wr_ctrl = reg_wr & hit(reg_addr, `CES_OFF_CTRL);
    assign wr_arg  = reg_wr & hit(reg_addr, `CES_OFF_ARG);

    // trigger line conditioning
    ces_trig_cond u_cond (
        .clk       (clk),
        .srst      (srst),
        .trig_line (trig_line),
        .pol_low   (pol_low),
        .active    (line_act),
        .activate  (line_rise)
    );

    // control word, host writes while idle by convention
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_ff <= `CES_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_ff <= reg_wdata[`CES_CTRL_W-1:0];
        end
    end

    // argument, shutter and period words
    always_ff @(posedge clk) begin
        if (srst) begin
            arg_ff     <= ARG_RST;
            shutter_ff <= SHUT_RST;
            period_ff  <= PER_RST;
        end else if (reg_wr) begin
            if (wr_arg) begin
                arg_ff <= reg_wdata[ARG_W-1:0];
            end
            if (hit(reg_addr, `CES_OFF_SHUTTER)) begin
                shutter_ff <= reg_wdata[TIME_W-1:0];
            end
            if (hit(reg_addr, `CES_OFF_PERIOD)) begin
                period_ff <= reg_wdata[TIME_W-1:0];
            end
        end
    end

    // software trigger command, one-cycle pulse from a write
    always_ff @(posedge clk) begin
        if (srst) begin
            sw_cmd_ff <= 1'b0;
        end else begin
            sw_cmd_ff <= reg_wr & hit(reg_addr, `CES_OFF_SWTRIG) &
                         reg_wdata[`CES_SWTRIG_BIT] & src_sw;
        end
    end

    // activation from whichever source is selected
    assign hw_or_sw_rise = src_sw ? sw_cmd_ff : line_rise;
    // gated level; a software pulse has no level, so shutter timing stands in
    assign level_now     = line_act;

    // ---------------- internal periodic trigger ----------------
    // runs only in periodic mode while acquisition is enabled
    assign per_run  = acq_en & (mode == ces_pkg::mode_internal_periodic);
    assign sub_load = per_run & ((state_ff == ces_pkg::st_idle) | sub_exp);

    // one fastest frame period
    ces_tick_timer #(
        .W (TIME_W)
    ) u_sub (
        .clk      (clk),
        .srst     (srst),
        .load     (sub_load),
        .load_val ((period_ff == '0) ? TIME_ONE : period_ff),
        .stop     (~per_run),
        .expire   (sub_exp)
    );

    // counts fastest periods; tick after N of them
    always_ff @(posedge clk) begin
        if (srst) begin
            per_cnt_ff <= '0;
        end else if (!per_run) begin
            per_cnt_ff <= '0;
        end else if (sub_exp) begin
            if (per_cnt_ff + ARG_ONE >= arg_ff) begin
                per_cnt_ff <= '0;
            end else begin
                per_cnt_ff <= per_cnt_ff + ARG_ONE;
            end
        end
    end

    // N of zero is served as one
    assign int_tick = per_run & sub_exp & (per_cnt_ff + ARG_ONE >= arg_ff);

    // ---------------- sequence start selection ----------------
    always_comb begin
        unique case (mode)
            ces_pkg::mode_trig_off: begin
                start_evt = 1'b1;
            end
            ces_pkg::mode_internal_periodic: begin
                start_evt = int_tick;
            end
            default: begin
                start_evt = hw_or_sw_rise;
            end
        endcase
    end

    // ---------------- shutter timer ----------------
    // loaded at every exposure start; a process sees what the function reads
    always_comb begin
        shut_load = frame_start_c();
    end

    // exposure start condition, shared by timer and strobe
    function automatic logic frame_start_c();
        frame_start_c = ((state_ff == ces_pkg::st_arm) && acq_en && start_evt) ||
                        ((state_ff == ces_pkg::st_between) && start_evt) ||
                        ((state_ff == ces_pkg::st_expose) && expo_end && !seq_last &&
                         (mode == ces_pkg::mode_shutter_timed_multi_frame));
    endfunction

    ces_tick_timer #(
        .W (TIME_W)
    ) u_shut (
        .clk      (clk),
        .srst     (srst),
        .load     (shut_load),
        .load_val ((shutter_ff == '0) ? TIME_ONE : shutter_ff),
        .stop     (state_ff != ces_pkg::st_expose),
        .expire   (shut_exp)
    );

    // ---------------- exposure end per mode ----------------
    always_comb begin
        unique case (mode)
            ces_pkg::mode_level_gated_single,
            ces_pkg::mode_level_gated_multi_frame: begin
                // line source ends on inactive level
                expo_end = src_sw ? shut_exp : ~level_now;
            end
            ces_pkg::mode_multi_pulse_accumulate: begin
                // later activations close the frame at the count
                expo_end = hw_or_sw_rise & (left_ff <= ARG_ONE);
            end
            default: begin
                expo_end = shut_exp;
            end
        endcase
    end

    // last frame of a multi-frame sequence
    assign seq_last = (left_ff <= ARG_ONE);

    // ---------------- state machine ----------------
    always_comb begin
        nxt_state = state_ff;
        nxt_left  = left_ff;
        unique case (state_ff)
            ces_pkg::st_idle: begin
                if (acq_en) begin
                    nxt_state = ces_pkg::st_arm;
                end
            end
            ces_pkg::st_arm: begin
                if (!acq_en) begin
                    nxt_state = ces_pkg::st_idle;
                end else if (start_evt) begin
                    nxt_state = ces_pkg::st_expose;
                    if (mode == ces_pkg::mode_multi_pulse_accumulate) begin
                        // first activation opened the frame; count the rest
                        nxt_left = (arg_ff < 2) ? ARG_ONE : arg_ff - ARG_ONE;
                    end else if (mode == ces_pkg::mode_shutter_timed_multi_frame ||
                                 mode == ces_pkg::mode_level_gated_multi_frame) begin
                        nxt_left = (arg_ff == '0) ? ARG_ONE : arg_ff;
                    end else begin
                        nxt_left = ARG_ONE;
                    end
                end
            end
            ces_pkg::st_expose: begin
                if (mode == ces_pkg::mode_multi_pulse_accumulate) begin
                    // activations during the frame are counted
                    if (expo_end) begin
                        nxt_state = ces_pkg::st_xfer;
                    end else if (hw_or_sw_rise) begin
                        nxt_left = left_ff - ARG_ONE;
                    end
                end else if (expo_end) begin
                    if (seq_last) begin
                        nxt_state = ces_pkg::st_xfer;
                    end else begin
                        nxt_left = left_ff - ARG_ONE;
                        if (mode == ces_pkg::mode_level_gated_multi_frame) begin
                            nxt_state = ces_pkg::st_between;
                        end
                    end
                end
            end
            ces_pkg::st_between: begin
                // waits for the next activation of a gated multi-frame
                if (start_evt) begin
                    nxt_state = ces_pkg::st_expose;
                end
            end
            ces_pkg::st_xfer: begin
                // activations here are dropped
                if (xfer_done) begin
                    nxt_state = acq_en ? ces_pkg::st_arm : ces_pkg::st_idle;
                end
            end
            default: begin
                nxt_state = ces_pkg::st_idle;
            end
        endcase
    end

    // state and count registers
    always_ff @(posedge clk) begin
        if (srst) begin
            state_ff <= ces_pkg::st_idle;
            left_ff  <= '0;
        end else begin
            state_ff <= nxt_state;
            left_ff  <= nxt_left;
        end
    end

    // exposure start strobe, registered
    always_ff @(posedge clk) begin
        if (srst) begin
            frame_st_ff <= 1'b0;
        end else begin
            frame_st_ff <= shut_load;
        end
    end

    // completed transfer counter
    always_ff @(posedge clk) begin
        if (srst) begin
            frames_ff <= 16'h0000;
        end else if ((state_ff == ces_pkg::st_xfer) && xfer_done) begin
            frames_ff <= frames_ff + 16'h0001;
        end
    end

    // ---------------- read port ----------------
    // data valid the cycle after the strobe, zero otherwise
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_ff <= '0;
        end else if (!reg_rd) begin
            rdata_ff <= '0;
        end else begin
            rdata_ff <= '0;
            if (hit(reg_addr, `CES_OFF_CTRL)) begin
                rdata_ff[`CES_CTRL_W-1:0] <= ctrl_ff;
            end
            if (hit(reg_addr, `CES_OFF_ARG)) begin
                rdata_ff[ARG_W-1:0] <= arg_ff;
            end
            if (hit(reg_addr, `CES_OFF_SHUTTER)) begin
                rdata_ff[TIME_W-1:0] <= shutter_ff;
            end
            if (hit(reg_addr, `CES_OFF_PERIOD)) begin
                rdata_ff[TIME_W-1:0] <= period_ff;
            end
            if (hit(reg_addr, `CES_OFF_STATUS)) begin
                rdata_ff[`CES_STAT_STATE_MSB:`CES_STAT_STATE_LSB] <= state_ff;
                rdata_ff[`CES_STAT_LINE_BIT] <= line_act;
                rdata_ff[`CES_STAT_LEFT_LSB +: 16] <= 16'(left_ff);
            end
            if (hit(reg_addr, `CES_OFF_FRAMES)) begin
                rdata_ff[15:0] <= frames_ff;
            end
        end
    end

    // outputs
    assign reg_rdata   = rdata_ff;
    assign integrating = (state_ff == ces_pkg::st_expose);
    assign frame_start = frame_st_ff;
    assign xfer_req    = (state_ff == ces_pkg::st_xfer);

endmodule // ces_sequencer
`default_nettype wire

//--- tb/ces_sequencer_checker.sv
// port assertions for the exposure trigger sequencer
`timescale 1ns/1ns
`default_nettype none
`include "ces_defs.svh"
module ces_sequencer_checker (
    input wire logic                   clk,
    input wire logic                   srst,
    input wire logic                   trig_line,
    input wire logic [`CES_ADDR_W-1:0] reg_addr,
    input wire logic [`CES_DATA_W-1:0] reg_wdata,
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire logic [`CES_DATA_W-1:0] reg_rdata,
    input wire logic                   xfer_done,
    input wire logic                   integrating,
    input wire logic                   frame_start,
    input wire logic                   xfer_req
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    chk_start_in_expose: assert property (frame_start |-> integrating)
        else $error("frame start outside exposure");
    chk_rise_gives_start: assert property ($rose(integrating) |-> frame_start)
        else $error("exposure began without frame start");
    chk_no_overlap: assert property (!(integrating && xfer_req))
        else $error("exposing while image waits");
    chk_xfer_after_expose: assert property ($rose(xfer_req) |-> $past(integrating))
        else $error("transfer request without exposure");
    chk_xfer_holds: assert property (xfer_req && !xfer_done |=> xfer_req)
        else $error("transfer request dropped early");
    chk_xfer_release: assert property (xfer_req && xfer_done |=> !xfer_req[*2])
        else $error("transfer request held after done");
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data outside read slot");
    chk_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) == 8'h1C
        |-> reg_rdata == '0)
        else $error("unmapped read not zero");
    cover property ($rose(xfer_req));
    cover property (frame_start && $past(integrating));
    cover property (xfer_req && xfer_done);
endmodule // ces_sequencer_checker
bind ces_sequencer ces_sequencer_checker chk_i (.clk, .srst, .trig_line, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .xfer_done, .integrating, .frame_start,
    .xfer_req);
`default_nettype wire

//--- tb/ces_xfer_partner.sv
// image transport model that takes each finished image
`timescale 1ns/1ns
`default_nettype none
module ces_xfer_partner (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic xfer_req,
    output logic      xfer_done
);
    int wait_n;  // cycles left before taking the image
    // takes the image after a random delay, done is a one-cycle pulse
    always @(posedge clk) begin
        if (srst || !xfer_req || xfer_done) begin
            xfer_done <= 1'b0;
            wait_n <= 1 + $urandom % 3;
        end else if (wait_n == 0) begin
            xfer_done <= 1'b1;
        end else begin
            wait_n <= wait_n - 1;
        end
    end
endmodule // ces_xfer_partner
`default_nettype wire

//--- tb/tb.sv
// self-checking bench for the exposure trigger sequencer
`timescale 1ns/1ns
`default_nettype none
`include "ces_defs.svh"
module tb;
    logic        clk, srst, trig_line, reg_wr, reg_rd, xfer_done, xfer_q;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic        integrating, frame_start, xfer_req;
    int          fail_count, total_checks, fs_n, xf_n, xf_tot, cyc, t_last, t_gap;
    ces_sequencer uut (.clk, .srst, .trig_line, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .xfer_done, .integrating, .frame_start, .xfer_req);
    ces_xfer_partner far_end (.clk, .srst, .xfer_req, .xfer_done);
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // counts frame starts and transfers, gap between the last two starts
    always @(posedge clk) begin
        cyc <= cyc + 1;
        xfer_q <= xfer_req;
        if (frame_start === 1'b1) begin
            fs_n <= fs_n + 1;
            t_gap <= cyc - t_last;
            t_last <= cyc;
        end
        if (xfer_req === 1'b1 && xfer_q !== 1'b1) xf_n <= xf_n + 1;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        check(reg_rdata, exp);
    endtask
    // model: frames and transfers from mode, argument and pulse spacing
    function automatic int mdl(input int m, arg, np, gap, input bit xf);
        int acc;
        acc = (gap < 10 && m != 2) ? 1 : np;
        case (m)
            2: return np / arg;
            4: return xf ? acc : acc * arg;
            5: return xf ? np / arg : np;
            default: return acc;
        endcase
    endfunction
    task automatic run(input int m, arg, np, hold, gap, win, input logic pol, src);
        trig_line <= pol;
        wr(`CES_OFF_ARG, arg);
        wr(`CES_OFF_CTRL, {26'h0, src, pol, m[2:0], 1'b0});
        repeat (30) @(posedge clk);
        fs_n <= 0;
        xf_n <= 0;
        wr(`CES_OFF_CTRL, {26'h0, src, pol, m[2:0], 1'b1});
        repeat (np) begin
            if (src) wr(`CES_OFF_SWTRIG, 32'h1);
            else begin
                trig_line <= ~pol;
                repeat (hold) @(posedge clk);
                trig_line <= pol;
            end
            repeat (gap) @(posedge clk);
        end
        repeat (win) @(posedge clk);
        wr(`CES_OFF_CTRL, {26'h0, src, pol, m[2:0], 1'b0});
        repeat (30) @(posedge clk);
        if (m == 3 || m == 6) begin
            check(fs_n > 0, 1);
            if (m == 3) check(t_gap, arg * 6);
        end else begin
            check(fs_n, mdl(m, arg, np, gap, 0));
            check(xf_n, mdl(m, arg, np, gap, 1));
            xf_tot += mdl(m, arg, np, gap, 1);
        end
        $display("test mode %0d done", m);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        srst = 1'b1;
        trig_line = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        void'($urandom(32'hC6C58694));
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rd(`CES_OFF_CTRL, 32'h0C);
        rd(`CES_OFF_ARG, 32'h1);
        rd(`CES_OFF_SHUTTER, 32'h64);
        rd(`CES_OFF_PERIOD, 32'h3E8);
        rd(8'h1C, 32'h0);
        wr(`CES_OFF_SHUTTER, 32'h3);
        wr(`CES_OFF_PERIOD, 32'h6);
        run(0, 1, 2, 2, 20 + $urandom % 5, 10, 1'b0, 1'b0);
        run(0, 1, 2, 2, 20, 10, 1'b1, 1'b0);
        run(0, 1, 2, 0, 20, 10, 1'b0, 1'b1);
        run(1, 1, 2, 3 + $urandom % 4, 20, 10, 1'b0, 1'b0);
        run(2, 3, 3, 2, 2, 20, 1'b0, 1'b0);
        run(4, 2, 2, 2, 1, 30, 1'b0, 1'b0);
        run(5, 2, 4, 4, 20, 10, 1'b1, 1'b0);
        rd(`CES_OFF_FRAMES, xf_tot);
        run(3, 2, 0, 0, 0, 60, 1'b0, 1'b0);
        run(6, 1, 2, 2, 20, 40, 1'b0, 1'b0);
        close_out;
    end
    // watchdog against a hung sequence
    initial begin
        #(100 * 20000);
        fail_count++;
        close_out;
    end
endmodule // tb
`default_nettype wire
